/* File: rtl/ms_timer.sv */
// Purpose: millisecond time base scaled by the clock frequency register
// Assumes: freq_mhz in 1..255, zero treated as one
// Notes: one tick per freq_mhz*1000 cycles
`timescale 1ns/1ps
module ms_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [7:0] freq_mhz,
  output logic tick
);
  logic [17:0] count;
  logic [17:0] limit;

  // cycles per scaled millisecond; zero acts as one, other values kept exact
  always_comb begin
    if (freq_mhz == 8'h00) begin
      limit = 18'd1000;
    end else begin
      limit = 18'({10'd0, freq_mhz} * 18'd1000);
    end
  end

  // counter restarts whenever run drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 18'h00000;
      tick <= 1'b0;
    end else if (!run) begin
      count <= 18'h00000;
      tick <= 1'b0;
    end else if (count >= limit - 18'd1) begin
      count <= 18'h00000;
      tick <= 1'b1;
    end else begin
      count <= count + 18'd1;
      tick <= 1'b0;
    end
  end
endmodule : ms_timer

/* File: rtl/smbus_ctrl.sv */
// Purpose: shift byte, own address and smbus control/status registers on APB
// Assumes: apb slave with zero wait states, inputs synchronous to pclk
// Notes: shift engine and status machine sit outside; this block holds their registers
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "smbus_ctrl_consts.svh"

// What this block does
// - 8-bit shift byte holds next byte to send or last received
// - data byte bit 7 is MSB, shifted out first
// - address call: bits 7..1 slave address, bit 0 direction, 1 read
// - own address in bits 7..1, register resets to zero
// - general call accept bit enables answering the general call address
// - writing one to bus reset bit holds clock low beyond 35 ms
// - bit 6 drives active-low suspend output, resets high
// - bit 5 reads the separate suspend input level
// - bit 4 drives wired-AND alert output, resets high
// - bit 3 reads the alert input level
// - bit 2 enables smbus timeouts, reset clear
// - bit 1 gates the timeout interrupt output
// - bit 0 gates the alert interrupt output
// - timeout counts scale from frequency register, 1..255, reset 8
module smbus_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic shift_load,
  input wire logic [7:0] shift_in_byte,
  input wire logic shift_bit_take,
  output logic shift_bit_msb,
  input wire logic [6:0] call_addr,
  input wire logic call_valid,
  output logic call_match,
  output logic call_read,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  output logic suspend_out_n,
  input wire logic suspend_in_n,
  output logic alert_out_n,
  output logic alert_oe,
  input wire logic alert_in_n,
  output logic smb_enable,
  output logic bus_timeout_irq,
  output logic alert_irq,
  output logic irq
);
  logic [7:0] shift_byte;
  logic [7:0] own_slave_address;
  logic [7:0] ctrl;
  logic [7:0] freq;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [5:0] ms_count;
  logic ms_tick;
  logic timeout_evt;
  logic reset_done_evt;
  logic [5:0] scl_low_ms;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [31:0] next_prdata;
  smbus_ctrl_pkg::bus_reset_state_t state;

  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;

  // address decode
  always_comb begin
    case (paddr)
      `OFF_SHIFT_BYTE, `OFF_OWN_ADDR, `OFF_SMB_CTRL, `OFF_FREQ, `OFF_IRQ_STATUS,
      `OFF_IRQ_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // read mux, live input levels in bits 5 and 3
  always_comb begin
    next_prdata = 32'h00000000;
    case (paddr)
      `OFF_SHIFT_BYTE: next_prdata[7:0] = shift_byte;
      `OFF_OWN_ADDR: next_prdata[7:0] = own_slave_address;
      `OFF_SMB_CTRL: begin
        next_prdata[7:0] = ctrl;
        next_prdata[`BIT_SUSPEND_IN] = suspend_in_n;
        next_prdata[`BIT_ALERT_IN] = alert_in_n;
      end
      `OFF_FREQ: next_prdata[7:0] = freq;
      `OFF_IRQ_STATUS: next_prdata[2:0] = irq_status;
      `OFF_IRQ_MASK: next_prdata[2:0] = irq_mask;
      default: next_prdata = 32'h00000000;
    endcase
  end

  // apb answer: data captured in setup, ready in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        prdata <= next_prdata;
      end
    end
  end

  // shift byte: software write, engine load, msb-first shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_byte <= `SHIFT_BYTE_RESET;
    end else if (wr_en && paddr == `OFF_SHIFT_BYTE) begin
      shift_byte <= pwdata[7:0];
    end else if (shift_load) begin
      shift_byte <= shift_in_byte;
    end else if (shift_bit_take) begin
      shift_byte <= {shift_byte[6:0], 1'b0};
    end
  end

  // outgoing bit and address-call direction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_bit_msb <= 1'b0;
      call_read <= 1'b0;
    end else begin
      shift_bit_msb <= shift_byte[7];
      call_read <= shift_byte[0];
    end
  end

  // own address and general call match
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_slave_address <= `OWN_ADDR_RESET;
      call_match <= 1'b0;
    end else begin
      if (wr_en && paddr == `OFF_OWN_ADDR) begin
        own_slave_address <= pwdata[7:0];
      end
      call_match <= call_valid && ((call_addr == own_slave_address[7:1]) ||
        (call_addr == `GENERAL_CALL_ADDR && own_slave_address[`BIT_GENERAL_CALL]));
    end
  end

  // control bits; bus reset bit self-clears when the hold ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 8'h50;
    end else if (wr_en && paddr == `OFF_SMB_CTRL) begin
      // a write in the cycle of the hold's end must not keep the old request
      ctrl <= {pwdata[7] | (ctrl[7] && !reset_done_evt), pwdata[6], 1'b0, pwdata[4], 1'b0,
        pwdata[2:0]};
    end else if (reset_done_evt) begin
      ctrl[`BIT_BUS_RESET] <= 1'b0;
    end
  end

  // frequency register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq <= `FREQ_RESET;
    end else if (wr_en && paddr == `OFF_FREQ) begin
      freq <= pwdata[7:0];
    end
  end

  ms_timer u_ms (
    .pclk(pclk),
    .presetn(presetn),
    .run(state == smbus_ctrl_pkg::ST_HOLD || (ctrl[`BIT_SMB_ENABLE] && !scl_in)),
    .freq_mhz(freq),
    .tick(ms_tick)
  );

  // bus reset hold: clock low until more than 35 ms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= smbus_ctrl_pkg::ST_IDLE;
      ms_count <= 6'd0;
      reset_done_evt <= 1'b0;
    end else begin
      reset_done_evt <= 1'b0;
      case (state)
        smbus_ctrl_pkg::ST_IDLE: begin
          ms_count <= 6'd0;
          // bit clears one cycle after the hold; its stale value must not restart it
          if (ctrl[`BIT_BUS_RESET] && !reset_done_evt) begin
            state <= smbus_ctrl_pkg::ST_HOLD;
          end
        end
        smbus_ctrl_pkg::ST_HOLD: begin
          if (ms_tick) begin
            if (ms_count == 6'(`BUS_RESET_MS)) begin
              state <= smbus_ctrl_pkg::ST_IDLE; // 36 ms elapsed
              reset_done_evt <= 1'b1;
            end else begin
              ms_count <= ms_count + 6'd1;
            end
          end
        end
        default: state <= smbus_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // clock-low timeout, only with smbus enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_low_ms <= 6'd0;
      timeout_evt <= 1'b0;
    end else begin
      timeout_evt <= 1'b0;
      if (!ctrl[`BIT_SMB_ENABLE] || scl_in || state == smbus_ctrl_pkg::ST_HOLD) begin
        scl_low_ms <= 6'd0;
      end else if (ms_tick) begin
        if (scl_low_ms == 6'(`TIMEOUT_MS - 1)) begin
          timeout_evt <= 1'b1;
        end
        if (scl_low_ms != 6'h3F) begin
          scl_low_ms <= scl_low_ms + 6'd1;
        end
      end
    end
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 3'h0;
      irq_mask <= 3'h0;
    end else begin
      if (wr_en && paddr == `OFF_IRQ_MASK) begin
        irq_mask <= pwdata[2:0];
      end
      irq_status <= (irq_status & ~((wr_en && paddr == `OFF_IRQ_STATUS) ? pwdata[2:0] : 3'h0))
        | {reset_done_evt, timeout_evt, !alert_in_n};
    end
  end

  // pins and interrupt outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_out <= 1'b1;
      scl_oe <= 1'b0;
      suspend_out_n <= 1'b1;
      alert_out_n <= 1'b1;
      alert_oe <= 1'b0;
      smb_enable <= 1'b0;
      bus_timeout_irq <= 1'b0;
      alert_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      scl_out <= 1'b0;
      scl_oe <= state == smbus_ctrl_pkg::ST_HOLD;
      suspend_out_n <= ctrl[`BIT_SUSPEND_OUT];
      alert_out_n <= ctrl[`BIT_ALERT_OUT];
      alert_oe <= !ctrl[`BIT_ALERT_OUT];
      smb_enable <= ctrl[`BIT_SMB_ENABLE];
      bus_timeout_irq <= ctrl[`BIT_TIMEOUT_IE] && irq_status[`IRQ_BIT_TIMEOUT];
      alert_irq <= ctrl[`BIT_ALERT_IE] && !alert_in_n;
      irq <= |(irq_status & irq_mask);
    end
  end

  // checks
  alert_irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ctrl[`BIT_ALERT_IE] || alert_in_n) |=> !alert_irq)
    else $error("alert irq without enable or alert");
  alert_irq_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[`BIT_ALERT_IE] && !alert_in_n) |=> alert_irq)
    else $error("alert irq missing");
  timeout_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl[`BIT_TIMEOUT_IE] |=> !bus_timeout_irq)
    else $error("timeout irq while disabled");
  suspend_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 suspend_out_n == $past(ctrl[`BIT_SUSPEND_OUT]))
    else $error("suspend pin mismatch");
  alert_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 alert_oe == !$past(ctrl[`BIT_ALERT_OUT]))
    else $error("alert enable not tied to level");
  hold_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == smbus_ctrl_pkg::ST_IDLE && ctrl[`BIT_BUS_RESET] && !reset_done_evt)
    |=> ##1 scl_oe)
    else $error("bus reset hold did not start");
  no_timeout_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl[`BIT_SMB_ENABLE] |=> !timeout_evt)
    else $error("timeout while smbus disabled");
  gc_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    (call_valid && call_addr == `GENERAL_CALL_ADDR && !own_slave_address[`BIT_GENERAL_CALL]
    && own_slave_address[7:1] != `GENERAL_CALL_ADDR)
    |=> !call_match)
    else $error("general call taken while not accepted");
  status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && paddr == `OFF_SMB_CTRL) |=> prdata[`BIT_ALERT_IN] == $past(alert_in_n))
    else $error("alert input status wrong");
endmodule : smbus_ctrl

/* File: rtl/smbus_ctrl_consts.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 50 MHz pclk, APB word registers
// Notes: definitions only
`ifndef SMBUS_CTRL_CONSTS_SVH
`define SMBUS_CTRL_CONSTS_SVH
`define OFF_SHIFT_BYTE 12'h000
`define OFF_OWN_ADDR 12'h004
`define OFF_SMB_CTRL 12'h008
`define OFF_FREQ 12'h00C
`define OFF_IRQ_STATUS 12'h010
`define OFF_IRQ_MASK 12'h014
`define SHIFT_BYTE_RESET 8'h00
`define OWN_ADDR_RESET 8'h00
`define FREQ_RESET 8'h08
`define BIT_BUS_RESET 7
`define BIT_SUSPEND_OUT 6
`define BIT_SUSPEND_IN 5
`define BIT_ALERT_OUT 4
`define BIT_ALERT_IN 3
`define BIT_SMB_ENABLE 2
`define BIT_TIMEOUT_IE 1
`define BIT_ALERT_IE 0
`define BIT_GENERAL_CALL 0
`define IRQ_BIT_ALERT 0
`define IRQ_BIT_TIMEOUT 1
`define IRQ_BIT_BUS_RESET_DONE 2
`define BUS_RESET_MS 35
`define TIMEOUT_MS 25
`define CYCLES_PER_US 20'd50
`define US_PER_MS 20'd1000
`define GENERAL_CALL_ADDR 7'h00
`endif

/* File: rtl/smbus_ctrl_pkg.sv */
// Purpose: types of the smbus control block
// Assumes: nothing
// Notes: constants live in the header
package smbus_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } bus_reset_state_t;
endpackage : smbus_ctrl_pkg

/* File: tb/i2c_smbus_data_addr_ctrl_bench.sv */
// Purpose: self-checking bench of the smbus control block
// Assumes: apb answer per hand-over, freq set to 1 for short ms
// Notes: row table first, then reset and hand-written cases
`timescale 1ns/1ps
`include "smbus_ctrl_consts.svh"
module i2c_smbus_data_addr_ctrl_bench;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] e;} row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err, shift_load = 0, shift_bit_take = 0, call_valid = 0;
  logic [7:0] shift_in_byte = 0;
  logic [6:0] call_addr = 0;
  logic shift_bit_msb, call_match, call_read, scl_in, scl_out, scl_oe, suspend_out_n;
  logic suspend_in_n = 1, alert_out_n, alert_oe, alert_in_n, smb_enable;
  logic bus_timeout_irq, alert_irq, irq, hold_scl = 0, pull_alert = 0, reset_seen;
  int fails = 0, n_checks = 0, cnt;
  row_t rows [6] = '{'{`OFF_SHIFT_BYTE, 32'hFFFFFF3C, 32'h3C}, '{`OFF_OWN_ADDR, 32'hAB, 32'hAB},
    '{`OFF_FREQ, 32'h01, 32'h01}, '{`OFF_IRQ_MASK, 32'h07, 32'h07},
    '{`OFF_SMB_CTRL, 32'h57, 32'h7F}, '{12'h018, 32'hFF, 32'h00}};
  smbus_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .shift_load, .shift_in_byte, .shift_bit_take, .shift_bit_msb,
    .call_addr, .call_valid, .call_match, .call_read, .scl_in, .scl_out, .scl_oe,
    .suspend_out_n, .suspend_in_n, .alert_out_n, .alert_oe, .alert_in_n, .smb_enable,
    .bus_timeout_irq, .alert_irq, .irq);
  smbus_peer i_peer (.pclk, .presetn, .scl_oe, .alert_oe, .hold_scl, .pull_alert,
    .scl_in, .alert_in_n, .reset_seen);
  always #10 pclk = ~pclk;
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      $display("Error at %0t: no ready on bus", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task wait_n(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : wait_n
  task call(input logic [6:0] a, input logic m);
    @(posedge pclk);
    call_addr <= a;
    call_valid <= 1;
    @(posedge pclk);
    call_valid <= 0;
    @(negedge pclk);
    chk(call_match, m);
  endtask : call
  task do_reset;
    @(posedge pclk);
    presetn <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
  endtask : do_reset
  // watchdog
  initial begin
    repeat (90000) @(posedge pclk);
    fails++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end
  initial begin
    do_reset();
    // table of write then read back
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].w);
      apb(0, rows[i].a, 0);
      chk(rd, rows[i].e);
      chk(err, rows[i].a == 12'h018);
    end
    do_reset();
    wait_n(1);
    chk({suspend_out_n, alert_out_n, scl_oe, scl_out}, 4'b1100);
    apb(0, `OFF_SMB_CTRL, 0);
    chk(rd, 32'h78);
    apb(0, `OFF_OWN_ADDR, 0);
    chk(rd, 0);
    apb(0, `OFF_SHIFT_BYTE, 0);
    chk(rd, 0);
    apb(0, `OFF_FREQ, 0);
    chk(rd, 32'h08);
    // shift byte load, direction, msb first
    @(posedge pclk);
    shift_in_byte <= 8'hA5;
    shift_load <= 1;
    @(posedge pclk);
    shift_load <= 0;
    wait_n(2);
    chk({shift_bit_msb, call_read}, 2'b11);
    @(posedge pclk);
    shift_bit_take <= 1;
    @(posedge pclk);
    shift_bit_take <= 0;
    wait_n(2);
    chk(shift_bit_msb, 0);
    apb(0, `OFF_SHIFT_BYTE, 0);
    chk(rd, 32'h4A);
    // own address and general call
    apb(1, `OFF_OWN_ADDR, 32'h54);
    call(7'h2A, 1);
    call(7'h2B, 0);
    call(7'h00, 0);
    apb(1, `OFF_OWN_ADDR, 32'h55);
    call(7'h00, 1);
    // suspend lines
    apb(1, `OFF_SMB_CTRL, 32'h10);
    suspend_in_n <= 0;
    apb(0, `OFF_SMB_CTRL, 0);
    chk(suspend_out_n, 0);
    chk(rd, 32'h18);
    suspend_in_n <= 1;
    // alert from far side, then own alert drive
    pull_alert <= 1;
    apb(1, `OFF_SMB_CTRL, 32'h51);
    wait_n(3);
    chk(alert_irq, 1);
    apb(1, `OFF_SMB_CTRL, 32'h50);
    wait_n(3);
    chk({alert_irq, irq}, 2'b00);
    @(posedge pclk);
    pull_alert <= 0;
    apb(1, `OFF_SMB_CTRL, 32'h41);
    apb(0, `OFF_SMB_CTRL, 0);
    chk(alert_oe, 1);
    chk(rd, 32'h61);
    apb(1, `OFF_IRQ_MASK, 32'h01);
    wait_n(2);
    chk(irq, 1);
    apb(1, `OFF_SMB_CTRL, 32'h50);
    apb(1, `OFF_IRQ_STATUS, 32'h01);
    wait_n(2);
    chk(irq, 0);
    // bus reset hold, freq 1
    apb(1, `OFF_FREQ, 32'h01);
    apb(1, `OFF_SMB_CTRL, 32'hD0);
    wait_n(3);
    cnt = 0;
    while (scl_oe === 1'b1 && cnt < 40000) begin
      @(negedge pclk);
      cnt++;
    end
    chk(cnt > 35000 && cnt < 36100, 1);
    chk(reset_seen, 1);
    apb(0, `OFF_SMB_CTRL, 0);
    chk(rd[7], 0);
    // timeout, gated by the timeout interrupt enable bit
    apb(1, `OFF_SMB_CTRL, 32'h56);
    hold_scl <= 1;
    cnt = 0;
    while (bus_timeout_irq !== 1'b1 && cnt < 30000) begin
      @(negedge pclk);
      cnt++;
    end
    chk(cnt >= 25000 && cnt < 25100, 1);
    chk(smb_enable, 1);
    @(posedge pclk);
    hold_scl <= 0;
    apb(0, `OFF_IRQ_STATUS, 0);
    chk(rd[1], 1);
    apb(1, `OFF_SMB_CTRL, 32'h54);
    wait_n(2);
    chk({bus_timeout_irq, irq}, 2'b00);
    apb(1, `OFF_IRQ_STATUS, 32'h02);
    apb(0, `OFF_IRQ_STATUS, 0);
    chk(rd[1], 0);
    final_report();
  end
endmodule : i2c_smbus_data_addr_ctrl_bench

/* File: tb/smbus_peer.sv */
// Purpose: far side of the two-wire bus, pull-ups and one slave
// Assumes: open-drain clock and alert lines with pull-ups
// Notes: low limit in pclk cycles, freq register set to 1
`timescale 1ns/1ps
module smbus_peer #(
  parameter int LOW_LIMIT = 35000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl_oe,
  input wire logic alert_oe,
  input wire logic hold_scl,
  input wire logic pull_alert,
  output logic scl_in,
  output logic alert_in_n,
  output logic reset_seen
);
  int low_cnt;
  // wired-AND lines, high when nobody pulls
  assign scl_in = !(scl_oe || hold_scl);
  assign alert_in_n = !(alert_oe || pull_alert);
  // slave returns to reset after a long clock low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt <= 0;
      reset_seen <= 1'b0;
    end else begin
      low_cnt <= scl_in ? 0 : low_cnt + 1;
      if (low_cnt > LOW_LIMIT) begin
        reset_seen <= 1'b1;
      end
    end
  end
endmodule : smbus_peer
